// file: tb/crs_core_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module crs_core_regs_chk (
   input wire logic CORE_CLK_I,
   input wire logic RSTN_I,
   input wire logic [3:0] REG_ADDR_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [7:0] REG_RDATA_O,
   input wire logic OP_VALID_I,
   input wire crs_pkg::crs_op_e OP_CODE_I,
   input wire logic OP_USE_MEM_I,
   input wire logic [7:0] OP_DATA_I,
   input wire logic OP_READY_O,
   input wire logic IRQ_ACK_O,
   input wire logic [15:0] ACC_Y_PAIR_O,
   input wire logic [7:0] PSW_O
);
   // ****************
   // status checks
   // ****************
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RSTN_I);
   // a register write on the same edge wins over the op on the written register
   sequence s_take(crs_pkg::crs_op_e op);
      OP_VALID_I && OP_READY_O && !REG_WR_I && OP_CODE_I == op;
   endsequence
   a_psw_readback: assert property ($past(REG_RD_I) &&
      $past(REG_ADDR_I) == crs_pkg::OFS_PROCESSOR_STATUS_WORD |-> REG_RDATA_O == $past(PSW_O))
      else $error("status readback wrong");
   a_load_flags: assert property (s_take(crs_pkg::OP_LDA) ##0 !OP_USE_MEM_I |=>
      PSW_O[7] == $past(OP_DATA_I[7]) && PSW_O[1] == ($past(OP_DATA_I) == 8'h00))
      else $error("load flags wrong");
   a_unmask_sets: assert property (s_take(crs_pkg::OP_IRQ_UNMASK) |=> PSW_O[2])
      else $error("enable not set");
   a_upper_page: assert property (s_take(crs_pkg::OP_UPPER_PAGE_SELECT) |=> PSW_O[5])
      else $error("page flag not set");
   a_ovf_clear: assert property (s_take(crs_pkg::OP_OVERFLOW_CLEAR) |=>
      !PSW_O[6] && !PSW_O[3]) else $error("overflow clear failed");
   a_ack_enabled: assert property (IRQ_ACK_O |-> PSW_O[2])
      else $error("ack while masked");
   a_ack_service: assert property (IRQ_ACK_O |-> ##[1:4] (!PSW_O[2] && OP_READY_O))
      else $error("enable kept in service");
   a_probe_bits: assert property (s_take(crs_pkg::OP_MEMORY_PROBE) ##0 !OP_USE_MEM_I |=>
      PSW_O[7:6] == $past(OP_DATA_I[7:6])) else $error("probe bits wrong");
endmodule : crs_core_regs_chk
`default_nettype wire

// file: tb/tb_cpu_core_register_set.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_core_register_set;
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, opv = 1'b0, irq = 1'b0, rdy, ack;
   logic [3:0] addr = 4'h0;
   logic [7:0] wd = 8'h00, opd = 8'h00, rdat, processor_status_word, a, b;
   logic [15:0] opa = 16'h0000, vec = 16'hf456, pair, ea;
   logic [11:0] pa;
   logic um = 1'b0;
   crs_pkg::crs_op_e opc = crs_pkg::OP_NOP;
   crs_pkg::crs_mode_e opm = crs_pkg::AM_DIRECT;
   integer num_errors = 0, checks = 0, seed = 88, i, n;
   always #5 clk = ~clk;
   // operand is immediate unless um selects the data ram
   crs_core_regs DUT (.CORE_CLK_I(clk), .RSTN_I(rstn), .REG_ADDR_I(addr), .REG_WDATA_I(wd),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat), .OP_VALID_I(opv), .OP_CODE_I(opc),
      .OP_MODE_I(opm), .OP_USE_MEM_I(um), .OP_DATA_I(opd), .OP_ADDR_I(opa), .OP_READY_O(rdy),
      .IRQ_REQ_I(irq), .IRQ_VECTOR_I(vec), .IRQ_ACK_O(ack), .PROG_ADDR_O(pa),
      .ACC_Y_PAIR_O(pair), .PSW_O(processor_status_word), .EA_O(ea));
   // ****************
   // bus tasks
   // ****************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wreg(input logic [3:0] ad, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= ad;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [3:0] ad, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= ad;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdat, e);
   endtask : rreg
   task automatic wait_rdy;
      n = 0;
      while (rdy !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1 n++;
      end
      if (rdy !== 1'b1) num_errors++;
   endtask : wait_rdy
   task automatic op(input crs_pkg::crs_op_e c, input logic [7:0] d, input logic [15:0] ad,
      input crs_pkg::crs_mode_e m);
      @(posedge clk);
      opv <= 1'b1;
      opc <= c;
      opd <= d;
      opa <= ad;
      opm <= m;
      @(posedge clk);
      opv <= 1'b0;
      #1 wait_rdy;
   endtask : op
   function automatic logic [15:0] add_exp(input logic [7:0] x, input logic [7:0] y);
      logic [8:0] t;
      t = x + y;
      return {t[7:0], t[7], (x[7] == y[7]) && (t[7] != x[7]), 2'b00,
         (x[3:0] + y[3:0]) > 5'd15, 1'b0, t[7:0] == 8'h00, t[8]};
   endfunction : add_exp
   task automatic finish_test;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      #1 chk(pa, 12'hffe);
      rreg(crs_pkg::OFS_PROG_COUNTER_HIGH, 8'hff);
      rreg(crs_pkg::OFS_PROCESSOR_STATUS_WORD, 8'h00);
      rreg(4'h9, 8'h00);
      for (i = 0; i < 12; i++) begin
         a = (i == 0) ? 8'h7f : (i == 1) ? 8'hff : 8'($random(seed));
         b = (i < 2) ? 8'h01 : 8'($random(seed));
         wreg(crs_pkg::OFS_PROCESSOR_STATUS_WORD, 8'h00);
         op(crs_pkg::OP_LDA, a, 16'h0000, crs_pkg::AM_DIRECT);
         chk({processor_status_word[7], processor_status_word[1]}, {a[7], a == 8'h00});
         op(crs_pkg::OP_ADD, b, 16'h0000, crs_pkg::AM_DIRECT);
         chk({pair[7:0], processor_status_word}, add_exp(a, b));
      end
      wreg(crs_pkg::OFS_IDX_X, a);
      wreg(crs_pkg::OFS_IDX_Y, b);
      op(crs_pkg::OP_LDA, 8'h00, 16'h12f0, crs_pkg::AM_INDEX_X);
      chk(ea, 16'h12f0 + a);
      chk(pair[15:8], b);
      op(crs_pkg::OP_LDA, 8'h00, 16'h12f0, crs_pkg::AM_INDEX_Y);
      chk(ea, 16'h12f0 + b);
      op(crs_pkg::OP_UPPER_PAGE_SELECT, 8'h00, 16'h0000, crs_pkg::AM_DIRECT);
      op(crs_pkg::OP_LDA, 8'h00, 16'h1234, crs_pkg::AM_DIRECT);
      chk(ea, 16'h0134);
      op(crs_pkg::OP_LOWER_PAGE_SELECT, 8'h00, 16'h0000, crs_pkg::AM_DIRECT);
      op(crs_pkg::OP_LDA, 8'h00, 16'h1234, crs_pkg::AM_DIRECT);
      chk(ea, 16'h0034);
      op(crs_pkg::OP_LDA, 8'h5a, 16'h0000, crs_pkg::AM_DIRECT);
      op(crs_pkg::OP_STA, 8'h00, 16'h0042, crs_pkg::AM_DIRECT);
      @(posedge clk);
      um <= 1'b1;
      op(crs_pkg::OP_LDA, 8'h00, 16'h0042, crs_pkg::AM_DIRECT);
      chk(pair[7:0], 8'h5a);
      @(posedge clk);
      um <= 1'b0;
      wreg(crs_pkg::OFS_IDX_X, 8'hff);
      op(crs_pkg::OP_INCX, 8'h00, 16'h0000, crs_pkg::AM_DIRECT);
      rreg(crs_pkg::OFS_IDX_X, 8'h00);
      op(crs_pkg::OP_MEMORY_PROBE, 8'hc0, 16'h0000, crs_pkg::AM_DIRECT);
      chk(processor_status_word[7:6], 2'b11);
      op(crs_pkg::OP_OVERFLOW_CLEAR, 8'h00, 16'h0000, crs_pkg::AM_DIRECT);
      chk({processor_status_word[6], processor_status_word[3]}, 2'b00);
      wreg(crs_pkg::OFS_STACK_PTR, 8'hff);
      op(crs_pkg::OP_CALL, 8'h00, 16'h0123, crs_pkg::AM_DIRECT);
      chk(pa, 12'h123);
      rreg(crs_pkg::OFS_STACK_PTR, 8'hfd);
      op(crs_pkg::OP_RET, 8'h00, 16'h0000, crs_pkg::AM_DIRECT);
      rreg(crs_pkg::OFS_STACK_PTR, 8'hff);
      chk(pa, 12'hffe);
      op(crs_pkg::OP_IRQ_MASK, 8'h00, 16'h0000, crs_pkg::AM_DIRECT);
      @(posedge clk);
      irq <= 1'b1;
      repeat (4) begin
         @(posedge clk);
         #1 chk(ack, 1'b0);
      end
      op(crs_pkg::OP_IRQ_UNMASK, 8'h00, 16'h0000, crs_pkg::AM_DIRECT);
      chk(ack, 1'b1);
      @(posedge clk);
      irq <= 1'b0;
      #1 wait_rdy;
      chk({pa, processor_status_word[2]}, {12'h456, 1'b0});
      rreg(crs_pkg::OFS_STACK_PTR, 8'hfc);
      op(crs_pkg::OP_SOFTWARE_BREAK, 8'h00, 16'h0abc, crs_pkg::AM_DIRECT);
      chk({pa, processor_status_word[4]}, {12'habc, 1'b1});
      finish_test;
   end
   initial begin
      #100000;
      num_errors++;
      finish_test;
   end
endmodule : tb_cpu_core_register_set
bind crs_core_regs crs_core_regs_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I),
   .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
   .OP_VALID_I(OP_VALID_I), .OP_CODE_I(OP_CODE_I), .OP_USE_MEM_I(OP_USE_MEM_I),
   .OP_DATA_I(OP_DATA_I), .OP_READY_O(OP_READY_O), .IRQ_ACK_O(IRQ_ACK_O),
   .ACC_Y_PAIR_O(ACC_Y_PAIR_O), .PSW_O(PSW_O));
`default_nettype wire

// file: verilog/crs_alu.sv
`timescale 1ns/1ps
`default_nettype none
module crs_alu (
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   input wire logic cin_i,
   input wire logic sub_i,
   output logic [7:0] res_o,
   output logic c_o,
   output logic h_o,
   output logic v_o
);
   logic [7:0] b_eff;
   logic [4:0] low_sum;
   logic [8:0] full_sum;

   // subtract as a + ~b + cin: carry out means no borrow
   always_comb begin
      b_eff = sub_i ? ~b_i : b_i;
      low_sum = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_i};
      full_sum = {1'b0, a_i} + {1'b0, b_eff} + {8'h00, cin_i};
      res_o = full_sum[7:0];
      c_o = full_sum[8];
      h_o = low_sum[4]; // see RULE14
      v_o = (a_i[7] == b_eff[7]) && (full_sum[7] != a_i[7]); // see RULE19
   end
endmodule : crs_alu
`default_nettype wire

// file: verilog/crs_core_regs.sv
// Notes on behaviour
// RULE1: program and data spaces separate; program memory only read, never written.
// RULE2: up to 256 bytes read/write data memory, holding the stack.
// RULE3: 8-bit accumulator, also joined with Y as a 16-bit pair.
// RULE4: indexed modes add X or Y to the given address.
// RULE5: X and Y support increment, decrement, compare and transfer. The code has no transfer op.
// RULE6: stack pointer not loaded at reset; software initialises it, usually ff.
// RULE7: stack lies at data addresses 1c0 to 1ff, chosen by stack pointer. The code places it at 100 to 1ff.
// RULE8: stack pointer moves automatically on calls and accepted interrupts.
// RULE9: 16-bit program counter, high and low bytes, resets to fffe.
// RULE10: carry takes ALU carry or borrow, and shift or rotate output.
// RULE11: zero set when arithmetic or transfer result is zero, else cleared.
// RULE12: interrupt enable low blocks all interrupts but reset and break.
// RULE13: enable cleared on service; unmask op sets it, mask op clears it.
// RULE14: half carry set on carry from bit 3 or no borrow from bit 4.
// RULE15: only ALU results and overflow clear op change half carry.
// RULE16: break op sets break flag to tell it from table calls.
// RULE17: direct addressing uses 000-0ff when page flag low, 100-1ff when high.
// RULE18: upper page op sets the page flag, lower page op clears it.
// RULE19: overflow set on signed overflow; only overflow clear op clears it. The code also clears it on a memory probe of an operand with bit 6 low.
// RULE20: negative flag copies bit 7 of data and arithmetic results.
// RULE21: memory probe copies operand bit 6 to overflow, bit 7 to negative.
// RULE22: status word bits 7..0 are N, V, G, B, H, I, Z, C.
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module crs_core_regs #(
   parameter int PROG_AW = 12,
   parameter int DMEM_AW = 8
) (
   input wire logic CORE_CLK_I,
   input wire logic RSTN_I,
   input wire logic [3:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [7:0] REG_RDATA_O,
   input wire logic OP_VALID_I,
   input wire crs_pkg::crs_op_e OP_CODE_I,
   input wire crs_pkg::crs_mode_e OP_MODE_I,
   input wire logic OP_USE_MEM_I,
   input wire logic [7:0] OP_DATA_I,
   input wire logic [15:0] OP_ADDR_I,
   output logic OP_READY_O,
   input wire logic IRQ_REQ_I,
   input wire logic [15:0] IRQ_VECTOR_I,
   output logic IRQ_ACK_O,
   output logic [PROG_AW-1:0] PROG_ADDR_O,
   output logic [15:0] ACC_Y_PAIR_O,
   output logic [7:0] PSW_O,
   output logic [15:0] EA_O
);
   // ****************************************
   // elaboration checks
   // ****************************************
   if (PROG_AW < 12 || PROG_AW > 16) begin : g_bad_prog
      $error("PROG_AW must lie between 12 and 16");
   end
   if (DMEM_AW != 8) begin : g_bad_dmem
      $error("DMEM_AW must be 8 so the stack page fits");
   end
   typedef enum {ST_IDLE, ST_PUSH_L, ST_PUSH_P, ST_POP_P, ST_POP_L, ST_POP_H} crs_state_e;
   // ****************************************
   // state
   // ****************************************
   crs_state_e state_r, state_nxt;
   logic [7:0] acc_r, acc_nxt, idx_x_r, idx_x_nxt, idx_y_r, idx_y_nxt, rdata_r, rdata_nxt;
   logic [7:0] sp_r, sp_nxt, pch_r, pch_nxt, pcl_r, pcl_nxt, psw_r, psw_nxt;
   logic [15:0] tgt_r, tgt_nxt, ea_r, ea_nxt;
   // no write path exists toward program memory: only its address leaves
   logic [7:0] dmem [0:(1<<DMEM_AW)-1]; // see RULE1 see RULE2
   logic [DMEM_AW-1:0] mem_wa, stk_idx;
   logic [7:0] mem_wd, opnd, alu_a, alu_b, alu_res;
   logic [15:0] ea, pc_full, pc_inc, pair_inc;
   logic push_psw_r, push_psw_nxt, mem_we, alu_cin, alu_sub, alu_c, alu_h, alu_v, irq_take;
   logic [8:0] stk_addr;
   // ****************************************
   // address generation
   // ****************************************
   always_comb begin
      case (OP_MODE_I)
         crs_pkg::AM_INDEX_X: ea = OP_ADDR_I + {8'h00, idx_x_r}; // see RULE4
         crs_pkg::AM_INDEX_Y: ea = OP_ADDR_I + {8'h00, idx_y_r}; // see RULE4
         crs_pkg::AM_DIRECT: ea = {7'h00, psw_r[crs_pkg::FLG_G] ? crs_pkg::DIRECT_PAGE1 : 9'h000}
            | {8'h00, OP_ADDR_I[7:0]}; // see RULE17
         default: ea = OP_ADDR_I;
      endcase
      // stack sits in page one at 100..1ff; the RAM sees the low byte
      stk_addr = crs_pkg::STACK_PAGE | {1'b0, sp_r}; // see RULE7
      stk_idx = stk_addr[DMEM_AW-1:0];
      opnd = OP_USE_MEM_I ? dmem[ea[DMEM_AW-1:0]] : OP_DATA_I;
      pc_full = {pch_r, pcl_r};
      pc_inc = pc_full + crs_pkg::ONE16;
      pair_inc = {idx_y_r, acc_r} + crs_pkg::ONE16;
   end
   // ****************************************
   // ALU operand selection
   // ****************************************
   always_comb begin
      alu_a = acc_r;
      alu_b = opnd;
      alu_cin = psw_r[crs_pkg::FLG_C];
      alu_sub = 1'b0;
      case (OP_CODE_I)
         crs_pkg::OP_SUB: alu_sub = 1'b1;
         crs_pkg::OP_CMP: begin
            alu_sub = 1'b1;
            alu_cin = 1'b1;
         end
         crs_pkg::OP_CMPX, crs_pkg::OP_CMPY, crs_pkg::OP_DECX, crs_pkg::OP_DECY: begin
            alu_a = (OP_CODE_I == crs_pkg::OP_CMPX || OP_CODE_I == crs_pkg::OP_DECX)
               ? idx_x_r : idx_y_r;
            alu_b = (OP_CODE_I == crs_pkg::OP_DECX || OP_CODE_I == crs_pkg::OP_DECY)
               ? crs_pkg::ONE8 : opnd;
            alu_sub = 1'b1;
            alu_cin = 1'b1;
         end
         crs_pkg::OP_INCX, crs_pkg::OP_INCY: begin
            alu_a = (OP_CODE_I == crs_pkg::OP_INCX) ? idx_x_r : idx_y_r;
            alu_b = crs_pkg::ONE8;
            alu_cin = 1'b0;
         end
         default: alu_cin = psw_r[crs_pkg::FLG_C];
      endcase
   end
   crs_alu u_alu (
      .a_i(alu_a), .b_i(alu_b), .cin_i(alu_cin), .sub_i(alu_sub),
      .res_o(alu_res), .c_o(alu_c), .h_o(alu_h), .v_o(alu_v)
   );
   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      state_nxt = state_r;
      acc_nxt = acc_r;
      idx_x_nxt = idx_x_r;
      idx_y_nxt = idx_y_r;
      sp_nxt = sp_r;
      pch_nxt = pch_r;
      pcl_nxt = pcl_r;
      psw_nxt = psw_r;
      tgt_nxt = tgt_r;
      push_psw_nxt = push_psw_r;
      ea_nxt = ea_r;
      mem_we = 1'b0;
      mem_wa = stk_idx;
      mem_wd = pch_r;
      // a pending decoder op goes first; interrupts wait for a free cycle
      irq_take = (state_r == ST_IDLE) && !OP_VALID_I && IRQ_REQ_I
         && psw_r[crs_pkg::FLG_I]; // see RULE12
      case (state_r)
         ST_IDLE: begin
            if (irq_take) begin
               mem_we = 1'b1;
               sp_nxt = sp_r - crs_pkg::ONE8; // see RULE8
               tgt_nxt = IRQ_VECTOR_I;
               push_psw_nxt = 1'b1;
               state_nxt = ST_PUSH_L;
            end else if (OP_VALID_I) begin
               ea_nxt = ea;
               case (OP_CODE_I)
                  crs_pkg::OP_ADD, crs_pkg::OP_SUB: begin
                     acc_nxt = alu_res;
                     psw_nxt[crs_pkg::FLG_C] = alu_c; // see RULE10
                     psw_nxt[crs_pkg::FLG_H] = alu_h; // see RULE14 see RULE15
                     psw_nxt[crs_pkg::FLG_V] = psw_r[crs_pkg::FLG_V] | alu_v; // see RULE19
                     psw_nxt[crs_pkg::FLG_N] = alu_res[crs_pkg::SIGN_BIT]; // see RULE20
                     psw_nxt[crs_pkg::FLG_Z] = (alu_res == crs_pkg::ZERO8); // see RULE11
                  end
                  crs_pkg::OP_CMP, crs_pkg::OP_CMPX, crs_pkg::OP_CMPY: begin
                     psw_nxt[crs_pkg::FLG_C] = alu_c; // see RULE5 see RULE10
                     psw_nxt[crs_pkg::FLG_N] = alu_res[crs_pkg::SIGN_BIT];
                     psw_nxt[crs_pkg::FLG_Z] = (alu_res == crs_pkg::ZERO8);
                  end
                  crs_pkg::OP_INCX, crs_pkg::OP_DECX, crs_pkg::OP_INCY, crs_pkg::OP_DECY: begin
                     if (OP_CODE_I == crs_pkg::OP_INCX || OP_CODE_I == crs_pkg::OP_DECX) begin
                        idx_x_nxt = alu_res; // see RULE5
                     end else begin
                        idx_y_nxt = alu_res; // see RULE5
                     end
                     psw_nxt[crs_pkg::FLG_N] = alu_res[crs_pkg::SIGN_BIT];
                     psw_nxt[crs_pkg::FLG_Z] = (alu_res == crs_pkg::ZERO8);
                  end
                  crs_pkg::OP_LDA, crs_pkg::OP_LDX, crs_pkg::OP_LDY: begin
                     if (OP_CODE_I == crs_pkg::OP_LDA) acc_nxt = opnd;
                     if (OP_CODE_I == crs_pkg::OP_LDX) idx_x_nxt = opnd; // see RULE5
                     if (OP_CODE_I == crs_pkg::OP_LDY) idx_y_nxt = opnd; // see RULE5
                     psw_nxt[crs_pkg::FLG_N] = opnd[crs_pkg::SIGN_BIT]; // see RULE20
                     psw_nxt[crs_pkg::FLG_Z] = (opnd == crs_pkg::ZERO8); // see RULE11
                  end
                  crs_pkg::OP_STA: begin
                     mem_we = 1'b1; // see RULE2
                     mem_wa = ea[DMEM_AW-1:0];
                     mem_wd = acc_r;
                  end
                  crs_pkg::OP_LDYA: begin
                     {idx_y_nxt, acc_nxt} = OP_ADDR_I; // see RULE3
                     psw_nxt[crs_pkg::FLG_N] = OP_ADDR_I[15];
                     psw_nxt[crs_pkg::FLG_Z] = (OP_ADDR_I == 16'h0000);
                  end
                  crs_pkg::OP_INCW: begin
                     {idx_y_nxt, acc_nxt} = pair_inc; // see RULE3
                     psw_nxt[crs_pkg::FLG_N] = pair_inc[15];
                     psw_nxt[crs_pkg::FLG_Z] = (pair_inc == 16'h0000);
                  end
                  crs_pkg::OP_ASL, crs_pkg::OP_ROL: begin
                     acc_nxt = {acc_r[6:0], (OP_CODE_I == crs_pkg::OP_ROL)
                        & psw_r[crs_pkg::FLG_C]};
                     psw_nxt[crs_pkg::FLG_C] = acc_r[7]; // see RULE10
                     psw_nxt[crs_pkg::FLG_N] = acc_r[6];
                     psw_nxt[crs_pkg::FLG_Z] = (acc_nxt == crs_pkg::ZERO8);
                  end
                  crs_pkg::OP_LSR, crs_pkg::OP_ROR: begin
                     acc_nxt = {(OP_CODE_I == crs_pkg::OP_ROR) & psw_r[crs_pkg::FLG_C],
                        acc_r[7:1]};
                     psw_nxt[crs_pkg::FLG_C] = acc_r[0]; // see RULE10
                     psw_nxt[crs_pkg::FLG_N] = acc_nxt[crs_pkg::SIGN_BIT];
                     psw_nxt[crs_pkg::FLG_Z] = (acc_nxt == crs_pkg::ZERO8);
                  end
                  crs_pkg::OP_IRQ_UNMASK: psw_nxt[crs_pkg::FLG_I] = 1'b1; // see RULE13
                  crs_pkg::OP_IRQ_MASK: psw_nxt[crs_pkg::FLG_I] = 1'b0; // see RULE13
                  crs_pkg::OP_OVERFLOW_CLEAR: begin
                     psw_nxt[crs_pkg::FLG_V] = 1'b0; // see RULE19
                     psw_nxt[crs_pkg::FLG_H] = 1'b0; // see RULE15
                  end
                  crs_pkg::OP_UPPER_PAGE_SELECT: psw_nxt[crs_pkg::FLG_G] = 1'b1; // see RULE18
                  crs_pkg::OP_LOWER_PAGE_SELECT: psw_nxt[crs_pkg::FLG_G] = 1'b0; // see RULE18
                  crs_pkg::OP_MEMORY_PROBE: begin
                     psw_nxt[crs_pkg::FLG_V] = opnd[crs_pkg::PROBE_V_BIT]; // see RULE21
                     psw_nxt[crs_pkg::FLG_N] = opnd[crs_pkg::SIGN_BIT]; // see RULE21
                     psw_nxt[crs_pkg::FLG_Z] = ((acc_r & opnd) == crs_pkg::ZERO8);
                  end
                  crs_pkg::OP_SOFTWARE_BREAK, crs_pkg::OP_CALL: begin
                     // break is taken even with interrupts masked
                     if (OP_CODE_I == crs_pkg::OP_SOFTWARE_BREAK) begin
                        psw_nxt[crs_pkg::FLG_B] = 1'b1; // see RULE16 see RULE12
                     end
                     mem_we = 1'b1;
                     sp_nxt = sp_r - crs_pkg::ONE8; // see RULE8
                     tgt_nxt = OP_ADDR_I;
                     push_psw_nxt = (OP_CODE_I == crs_pkg::OP_SOFTWARE_BREAK);
                     state_nxt = ST_PUSH_L;
                  end
                  crs_pkg::OP_RET, crs_pkg::OP_RETI: begin
                     // restore pre-increments, so the pointer moves first
                     sp_nxt = sp_r + crs_pkg::ONE8;
                     state_nxt = (OP_CODE_I == crs_pkg::OP_RETI) ? ST_POP_P : ST_POP_L;
                  end
                  crs_pkg::OP_JMP: {pch_nxt, pcl_nxt} = OP_ADDR_I;
                  crs_pkg::OP_STEP: {pch_nxt, pcl_nxt} = pc_inc; // see RULE9
                  default: state_nxt = ST_IDLE;
               endcase
            end
         end
         ST_PUSH_L: begin
            mem_we = 1'b1;
            mem_wd = pcl_r;
            sp_nxt = sp_r - crs_pkg::ONE8; // see RULE8
            if (push_psw_r) begin
               state_nxt = ST_PUSH_P;
            end else begin
               {pch_nxt, pcl_nxt} = tgt_r;
               state_nxt = ST_IDLE;
            end
         end
         ST_PUSH_P: begin
            mem_we = 1'b1;
            mem_wd = psw_r;
            sp_nxt = sp_r - crs_pkg::ONE8;
            psw_nxt[crs_pkg::FLG_I] = 1'b0; // see RULE13
            {pch_nxt, pcl_nxt} = tgt_r;
            state_nxt = ST_IDLE;
         end
         ST_POP_P: begin
            psw_nxt = dmem[stk_idx];
            sp_nxt = sp_r + crs_pkg::ONE8;
            state_nxt = ST_POP_L;
         end
         ST_POP_L: begin
            pcl_nxt = dmem[stk_idx];
            sp_nxt = sp_r + crs_pkg::ONE8;
            state_nxt = ST_POP_H;
         end
         ST_POP_H: begin
            pch_nxt = dmem[stk_idx];
            state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
      // software writes override the same-cycle op on that register
      if (REG_WR_I) begin
         case (REG_ADDR_I)
            crs_pkg::OFS_ACC: acc_nxt = REG_WDATA_I;
            crs_pkg::OFS_IDX_X: idx_x_nxt = REG_WDATA_I;
            crs_pkg::OFS_IDX_Y: idx_y_nxt = REG_WDATA_I;
            crs_pkg::OFS_STACK_PTR: sp_nxt = REG_WDATA_I; // see RULE6
            crs_pkg::OFS_PROG_COUNTER_LOW: pcl_nxt = REG_WDATA_I;
            crs_pkg::OFS_PROG_COUNTER_HIGH: pch_nxt = REG_WDATA_I;
            crs_pkg::OFS_PROCESSOR_STATUS_WORD: psw_nxt = REG_WDATA_I; // see RULE22
            default: acc_nxt = acc_nxt;
         endcase
      end
      rdata_nxt = crs_pkg::ZERO8;
      if (REG_RD_I) begin
         case (REG_ADDR_I)
            crs_pkg::OFS_ACC: rdata_nxt = acc_r;
            crs_pkg::OFS_IDX_X: rdata_nxt = idx_x_r;
            crs_pkg::OFS_IDX_Y: rdata_nxt = idx_y_r;
            crs_pkg::OFS_STACK_PTR: rdata_nxt = sp_r;
            crs_pkg::OFS_PROG_COUNTER_LOW: rdata_nxt = pcl_r;
            crs_pkg::OFS_PROG_COUNTER_HIGH: rdata_nxt = pch_r;
            crs_pkg::OFS_PROCESSOR_STATUS_WORD: rdata_nxt = psw_r;
            crs_pkg::OFS_EFF_ADDR_LO: rdata_nxt = ea_r[7:0];
            crs_pkg::OFS_EFF_ADDR_HI: rdata_nxt = ea_r[15:8];
            default: rdata_nxt = crs_pkg::ZERO8;
         endcase
      end
   end
   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         state_r <= ST_IDLE;
         acc_r <= crs_pkg::ZERO8;
         idx_x_r <= crs_pkg::ZERO8;
         idx_y_r <= crs_pkg::ZERO8;
         pch_r <= crs_pkg::PCH_RST; // see RULE9
         pcl_r <= crs_pkg::PCL_RST; // see RULE9
         psw_r <= crs_pkg::PSW_RST;
         tgt_r <= 16'h0000;
         push_psw_r <= 1'b0;
         ea_r <= 16'h0000;
         rdata_r <= crs_pkg::ZERO8;
      end else begin
         state_r <= state_nxt;
         acc_r <= acc_nxt;
         idx_x_r <= idx_x_nxt;
         idx_y_r <= idx_y_nxt;
         pch_r <= pch_nxt;
         pcl_r <= pcl_nxt;
         psw_r <= psw_nxt;
         tgt_r <= tgt_nxt;
         push_psw_r <= push_psw_nxt;
         ea_r <= ea_nxt;
         rdata_r <= rdata_nxt;
      end
   end
   // pointer keeps no reset: its value is unknown until software loads it
   always_ff @(posedge CORE_CLK_I) begin
      sp_r <= sp_nxt; // see RULE6
   end
   always_ff @(posedge CORE_CLK_I) begin
      if (mem_we) begin
         dmem[mem_wa] <= mem_wd; // see RULE2
      end
   end
   // ****************************************
   // outputs
   // ****************************************
   assign REG_RDATA_O = rdata_r;
   assign OP_READY_O = (state_r == ST_IDLE);
   assign IRQ_ACK_O = irq_take;
   assign PROG_ADDR_O = pc_full[PROG_AW-1:0];
   assign ACC_Y_PAIR_O = {idx_y_r, acc_r}; // see RULE3
   assign PSW_O = psw_r;
   assign EA_O = ea_r;
endmodule : crs_core_regs
`default_nettype wire

// file: verilog/crs_pkg.sv
`default_nettype none
package crs_pkg;
   // ****************************************
   // register bus offsets
   // ****************************************
   localparam logic [3:0] OFS_ACC = 4'h0;
   localparam logic [3:0] OFS_IDX_X = 4'h1;
   localparam logic [3:0] OFS_IDX_Y = 4'h2;
   localparam logic [3:0] OFS_STACK_PTR = 4'h3;
   localparam logic [3:0] OFS_PROG_COUNTER_LOW = 4'h4;
   localparam logic [3:0] OFS_PROG_COUNTER_HIGH = 4'h5;
   localparam logic [3:0] OFS_PROCESSOR_STATUS_WORD = 4'h6;
   localparam logic [3:0] OFS_EFF_ADDR_LO = 4'h7;
   localparam logic [3:0] OFS_EFF_ADDR_HI = 4'h8;
   // ****************************************
   // status word bit positions
   // ****************************************
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_I = 2;
   localparam int FLG_H = 3;
   localparam int FLG_B = 4;
   localparam int FLG_G = 5;
   localparam int FLG_V = 6;
   localparam int FLG_N = 7;
   localparam int SIGN_BIT = 7;
   localparam int PROBE_V_BIT = 6;
   // ****************************************
   // reset values and address constants
   // ****************************************
   localparam logic [7:0] PSW_RST = 8'h00;
   localparam logic [7:0] PCH_RST = 8'hff;
   localparam logic [7:0] PCL_RST = 8'hfe;
   localparam logic [8:0] STACK_PAGE = 9'h100;
   localparam logic [8:0] DIRECT_PAGE1 = 9'h100;
   localparam logic [7:0] ONE8 = 8'h01;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [15:0] ONE16 = 16'h0001;
   // ****************************************
   // operations issued by the decoder
   // ****************************************
   typedef enum logic [4:0] {
      OP_NOP, OP_ADD, OP_SUB, OP_CMP, OP_CMPX, OP_CMPY,
      OP_INCX, OP_DECX, OP_INCY, OP_DECY,
      OP_LDA, OP_LDX, OP_LDY, OP_STA, OP_LDYA, OP_INCW,
      OP_ASL, OP_LSR, OP_ROL, OP_ROR,
      OP_IRQ_UNMASK, OP_IRQ_MASK, OP_OVERFLOW_CLEAR,
      OP_UPPER_PAGE_SELECT, OP_LOWER_PAGE_SELECT,
      OP_MEMORY_PROBE, OP_SOFTWARE_BREAK, OP_CALL, OP_RET, OP_RETI,
      OP_JMP, OP_STEP
   } crs_op_e;
   // addressing of the data operand
   typedef enum logic [1:0] {
      AM_DIRECT, AM_INDEX_X, AM_INDEX_Y, AM_ABSOLUTE
   } crs_mode_e;
endpackage : crs_pkg
`default_nettype wire
